// ---- core/uaf_pkg.sv ----
// shared constants for the uart auto flow control block
package uaf_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_FIFO_CTRL = 8'h04;
  localparam logic [7:0] OFF_MODEM_CTRL = 8'h08;
  localparam logic [7:0] OFF_MODEM_STAT = 8'h0c;
  localparam logic [7:0] OFF_INT_STAT = 8'h10;
  localparam logic [7:0] OFF_INT_MASK = 8'h14;
  localparam logic [7:0] OFF_LINE_STAT = 8'h18;
  localparam logic [7:0] OFF_DIVISOR = 8'h1c;

  // modem control fields
  localparam int MC_DTR = 0;
  localparam int MC_REQ = 1;
  localparam int MC_LOOP = 4;
  localparam int MC_RSVD = 5;
  localparam int MC_AUTO_RTS = 6;
  localparam int MC_AUTO_CTS = 7;

  // fifo control fields
  localparam int FC_TRIG_LO = 6;
  localparam int FC_CTS_IE = 3;

  // modem status fields
  localparam int MS_DELTA_CTS = 0;
  localparam int MS_CTS = 4;

  // interrupt status / mask fields
  localparam int IS_RX_TRIG = 0;
  localparam int IS_TX_DONE = 1;
  localparam int IS_MODEM = 2;
  localparam int IS_OVERRUN = 3;
  localparam int IS_W = 4;

  // line status fields
  localparam int LS_COUNT_LO = 0;
  localparam int LS_TX_FULL = 8;
  localparam int LS_TX_IDLE = 9;

  // reset values
  localparam logic [1:0] RST_TRIG = 2'h0;
  localparam logic [15:0] RST_DIVISOR = 16'h000f;
  localparam logic [IS_W-1:0] RST_INT_MASK = 4'h0;

  // receive fifo geometry
  localparam int FIFO_AW = 4;
  localparam logic [FIFO_AW:0] FIFO_DEPTH = 5'h10;

  // trigger levels and the level below each one
  localparam logic [FIFO_AW:0] TRIG_L0 = 5'h01;
  localparam logic [FIFO_AW:0] TRIG_L1 = 5'h04;
  localparam logic [FIFO_AW:0] TRIG_L2 = 5'h08;
  localparam logic [FIFO_AW:0] TRIG_L3 = 5'h0e;
  localparam logic [FIFO_AW:0] TRIG_NONE = 5'h00;

  // serial frame: start, eight data, stop
  localparam logic [3:0] FRAME_LAST = 4'h9;
endpackage

// ---- core/uaf_tx_if.sv ----
// handshake between the flow control core and the transmit shifter
`timescale 1ns/100ps
interface uaf_tx_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  logic done;
  logic txd;
  modport core (output valid, output data, input ready, input done,
    input txd);
  modport shifter (input valid, input data, output ready, output done,
    output txd);
endinterface

// ---- core/uaf_rx_mem.sv ----
// receive fifo storage with registered, write-first read data
`timescale 1ns/100ps
module uaf_rx_mem
  import uaf_pkg::*;
(
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [FIFO_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // read port
  input wire logic [FIFO_AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [2**FIFO_AW];
  logic [7:0] next_rdata;

  // bypass so a byte pushed into an empty fifo is visible next cycle
  always_comb begin
    next_rdata = mem[raddr];
    if (we && (waddr == raddr)) begin
      next_rdata = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= next_rdata;
  end
endmodule

// ---- core/uaf_tx_shift.sv ----
// transmit shift register: one 8n1 character per start handshake
`timescale 1ns/100ps
module uaf_tx_shift
  import uaf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bit period minus one, in clocks
  input wire logic [15:0] divisor,
  // character handshake
  uaf_tx_if.shifter tx
);
  typedef enum logic {TX_IDLE, TX_SEND} uaf_tx_state_e;
  uaf_tx_state_e state, next_state;
  logic [9:0] shreg, next_shreg;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [15:0] baud_cnt, next_baud_cnt;
  logic txd, next_txd;
  logic done, next_done;

  assign tx.ready = (state == TX_IDLE);
  assign tx.txd = txd;
  assign tx.done = done;

  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bit_cnt = bit_cnt;
    next_baud_cnt = baud_cnt;
    next_txd = txd;
    next_done = 1'b0;
    case (state)
      TX_IDLE: begin
        // line stays marking while nothing may be started
        next_txd = 1'b1;
        if (tx.valid) begin
          next_shreg = {1'b1, tx.data, 1'b0};
          next_txd = 1'b0;
          next_bit_cnt = 4'h0;
          next_baud_cnt = 16'h0000;
          next_state = TX_SEND;
        end
      end
      TX_SEND: begin
        if (baud_cnt >= divisor) begin
          next_baud_cnt = 16'h0000;
          if (bit_cnt == FRAME_LAST) begin
            next_txd = 1'b1;
            next_done = 1'b1;
            next_state = TX_IDLE;
          end else begin
            next_shreg = {1'b1, shreg[9:1]};
            next_txd = shreg[1];
            next_bit_cnt = bit_cnt + 4'h1;
          end
        end else begin
          next_baud_cnt = baud_cnt + 16'h0001;
        end
      end
      default: begin
        next_state = TX_IDLE;
        next_txd = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= TX_IDLE;
      shreg <= 10'h3ff;
      bit_cnt <= 4'h0;
      baud_cnt <= 16'h0000;
      txd <= 1'b1;
      done <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bit_cnt <= next_bit_cnt;
      baud_cnt <= next_baud_cnt;
      txd <= next_txd;
      done <= next_done;
    end
  end
endmodule

// ---- core/uaf_flow_top.sv ----
// uart core with automatic rts/cts flow control and its register file
//
// Function
// - modem control bit 6 enables automatic rts, reset 0.
// - modem control bit 7 enables automatic cts, reset 0.
// - with automatic cts a new character starts only while cts is asserted.
// - the automatic rts decision follows the programmed receive trigger level.
// - with automatic rts, rts goes high once the fifo reaches the trigger.
// - rts goes low again once the fifo falls to the next lower trigger level.
// - one more byte arriving after rts went high is still accepted.
// - without automatic rts and outside loopback, the pin follows the software rts bit.
// - with automatic rts, the driven rts level is copied into the rts bit.
// - with automatic rts, software writes to the rts bit are ignored.
// - modem control bit 1 sources the rts pin and reads 0 in loopback.
// - with automatic cts, while cts is deasserted no new character starts; the current one completes and the line idles at one, then resumes normally.
// - a cts change sets delta cts always, but interrupts under automatic
//   cts only with the cts interrupt enable.
`timescale 1ns/100ps
module uaf_flow_top
  import uaf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // received bytes from the deserializer
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // modem pins, active low
  input wire logic cts_n,
  output logic rts_n,
  output logic dtr_n,
  // serial out and interrupt
  output logic txd,
  output logic irq
);
  uaf_tx_if tx_bus ();

  // cts pin synchroniser; first stage is read only by the second
  logic cts_meta;
  logic cts_sync;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cts_meta <= 1'b1;
      cts_sync <= 1'b1;
    end else begin
      cts_meta <= cts_n;
      cts_sync <= cts_meta;
    end
  end

  // control and status state
  logic dtr_bit, next_dtr_bit;
  logic req_bit, next_req_bit;
  logic loop_bit, next_loop_bit;
  logic auto_request_enable, next_auto_request_enable;
  logic auto_clear_enable, next_auto_clear_enable;
  logic [1:0] trig_sel, next_trig_sel;
  logic cts_int_en, next_cts_int_en;
  logic [15:0] divisor, next_divisor;
  logic [7:0] tx_hold, next_tx_hold;
  logic tx_full, next_tx_full;
  logic [FIFO_AW-1:0] wr_ptr, next_wr_ptr;
  logic [FIFO_AW-1:0] rd_ptr, next_rd_ptr;
  logic [FIFO_AW:0] count, next_count;
  logic rx_stop, next_rx_stop;
  logic next_rts_n;
  logic next_dtr_n;
  logic cts_prev, next_cts_prev;
  logic delta_cts, next_delta_cts;
  logic [IS_W-1:0] int_stat, next_int_stat;
  logic [IS_W-1:0] int_mask, next_int_mask;
  logic next_irq;
  logic [31:0] next_rdata;

  // combinational helpers
  logic cts_on;
  logic push, pop, tx_start;
  logic [FIFO_AW:0] trig_lvl, prev_lvl;
  logic [IS_W-1:0] events, w1c;
  logic [7:0] mem_q;

  uaf_rx_mem u_mem (
    .clk(clk),
    .we(push),
    .waddr(wr_ptr),
    .wdata(rx_data),
    .raddr(next_rd_ptr),
    .rdata(mem_q)
  );

  uaf_tx_shift u_tx (
    .clk(clk),
    .rst_n(rst_n),
    .divisor(divisor),
    .tx(tx_bus.shifter)
  );

  assign txd = tx_bus.txd;
  assign tx_bus.data = tx_hold;
  assign tx_bus.valid = tx_start;

  always_comb begin
    // in loopback cts is fed from our own rts bit, not the pin
    cts_on = loop_bit ? req_bit : ~cts_sync;
    tx_start = tx_full && (!auto_clear_enable || cts_on);

    case (trig_sel)
      2'h0: begin
        trig_lvl = TRIG_L0;
        prev_lvl = TRIG_NONE;
      end
      2'h1: begin
        trig_lvl = TRIG_L1;
        prev_lvl = TRIG_L0;
      end
      2'h2: begin
        trig_lvl = TRIG_L2;
        prev_lvl = TRIG_L1;
      end
      default: begin
        trig_lvl = TRIG_L3;
        prev_lvl = TRIG_L2;
      end
    endcase

    // full depth stays above the top trigger, leaving room for late bytes
    push = rx_valid && (count != FIFO_DEPTH);
    pop = rd_en && (addr == OFF_DATA) && (count != TRIG_NONE);

    next_dtr_bit = dtr_bit;
    next_req_bit = req_bit;
    next_loop_bit = loop_bit;
    next_auto_request_enable = auto_request_enable;
    next_auto_clear_enable = auto_clear_enable;
    next_trig_sel = trig_sel;
    next_cts_int_en = cts_int_en;
    next_divisor = divisor;
    next_tx_hold = tx_hold;
    next_tx_full = tx_full && !(tx_start && tx_bus.ready);
    next_int_mask = int_mask;
    w1c = '0;

    if (wr_en) begin
      case (addr)
        OFF_DATA: begin
          // a write while the holding byte is pending is dropped
          if (!tx_full) begin
            next_tx_hold = wdata[7:0];
            next_tx_full = 1'b1;
          end
        end
        OFF_FIFO_CTRL: begin
          next_trig_sel = wdata[FC_TRIG_LO+1:FC_TRIG_LO];
          next_cts_int_en = wdata[FC_CTS_IE];
        end
        OFF_MODEM_CTRL: begin
          next_dtr_bit = wdata[MC_DTR];
          next_loop_bit = wdata[MC_LOOP];
          next_auto_request_enable = wdata[MC_AUTO_RTS];
          next_auto_clear_enable = wdata[MC_AUTO_CTS];
          if (!auto_request_enable) begin
            next_req_bit = wdata[MC_REQ];
          end
        end
        OFF_INT_STAT: w1c = wdata[IS_W-1:0];
        OFF_INT_MASK: next_int_mask = wdata[IS_W-1:0];
        OFF_DIVISOR: next_divisor = wdata[15:0];
        default: begin
        end
      endcase
    end

    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end

    // thresholds seen on the new level so the pin moves with the count
    next_rx_stop = rx_stop;
    if (next_count >= trig_lvl) begin
      next_rx_stop = 1'b1;
    end else if (next_count <= prev_lvl) begin
      next_rx_stop = 1'b0;
    end

    if (next_auto_request_enable) begin
      next_req_bit = ~next_rx_stop;
    end
    // loopback forces the external modem outputs inactive
    next_rts_n = next_loop_bit ? 1'b1 : ~next_req_bit;
    next_dtr_n = next_loop_bit ? 1'b1 : ~next_dtr_bit;

    next_cts_prev = cts_on;
    next_delta_cts = delta_cts;
    if (rd_en && (addr == OFF_MODEM_STAT)) begin
      next_delta_cts = 1'b0;
    end
    if (cts_on != cts_prev) begin
      next_delta_cts = 1'b1;
    end

    events = '0;
    events[IS_RX_TRIG] = next_rx_stop && !rx_stop;
    events[IS_TX_DONE] = tx_bus.done;
    events[IS_MODEM] = (cts_on != cts_prev) &&
      (!auto_clear_enable || cts_int_en);
    events[IS_OVERRUN] = rx_valid && !push;
    // a new event wins over a clear in the same cycle
    next_int_stat = (int_stat & ~w1c) | events;
    next_irq = |(next_int_stat & next_int_mask);

    next_rdata = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        OFF_DATA: next_rdata[7:0] = mem_q;
        OFF_FIFO_CTRL: begin
          next_rdata[FC_TRIG_LO+1:FC_TRIG_LO] = trig_sel;
          next_rdata[FC_CTS_IE] = cts_int_en;
        end
        OFF_MODEM_CTRL: begin
          next_rdata[MC_DTR] = loop_bit ? 1'b0 : dtr_bit;
          next_rdata[MC_REQ] = loop_bit ? 1'b0 : req_bit;
          next_rdata[MC_LOOP] = loop_bit;
          next_rdata[MC_AUTO_RTS] = auto_request_enable;
          next_rdata[MC_AUTO_CTS] = auto_clear_enable;
        end
        OFF_MODEM_STAT: begin
          next_rdata[MS_DELTA_CTS] = delta_cts;
          next_rdata[MS_CTS] = cts_on;
        end
        OFF_INT_STAT: next_rdata[IS_W-1:0] = int_stat;
        OFF_INT_MASK: next_rdata[IS_W-1:0] = int_mask;
        OFF_LINE_STAT: begin
          next_rdata[LS_COUNT_LO+FIFO_AW:LS_COUNT_LO] = count;
          next_rdata[LS_TX_FULL] = tx_full;
          next_rdata[LS_TX_IDLE] = tx_bus.ready;
        end
        OFF_DIVISOR: next_rdata[15:0] = divisor;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dtr_bit <= 1'b0;
      req_bit <= 1'b0;
      loop_bit <= 1'b0;
      auto_request_enable <= 1'b0;
      auto_clear_enable <= 1'b0;
      trig_sel <= RST_TRIG;
      cts_int_en <= 1'b0;
      divisor <= RST_DIVISOR;
      tx_hold <= 8'h00;
      tx_full <= 1'b0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      rx_stop <= 1'b0;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      cts_prev <= 1'b0;
      delta_cts <= 1'b0;
      int_stat <= '0;
      int_mask <= RST_INT_MASK;
      irq <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      dtr_bit <= next_dtr_bit;
      req_bit <= next_req_bit;
      loop_bit <= next_loop_bit;
      auto_request_enable <= next_auto_request_enable;
      auto_clear_enable <= next_auto_clear_enable;
      trig_sel <= next_trig_sel;
      cts_int_en <= next_cts_int_en;
      divisor <= next_divisor;
      tx_hold <= next_tx_hold;
      tx_full <= next_tx_full;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      rx_stop <= next_rx_stop;
      rts_n <= next_rts_n;
      dtr_n <= next_dtr_n;
      cts_prev <= next_cts_prev;
      delta_cts <= next_delta_cts;
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
      irq <= next_irq;
      rdata <= next_rdata;
    end
  end
endmodule

// ---- dv/uaf_flow_properties.sv ----
// port assertions for the flow control block
`timescale 1ns/100ps
module uaf_flow_properties
  import uaf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  // stream and pins
  input wire logic rx_valid,
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic txd,
  input wire logic irq
);
  logic au, ac, lp, sw, rq;
  logic [1:0] sel;
  logic [3:0] msk;
  logic [15:0] dv;
  logic [4:0] cnt, trig, lo;
  logic [19:0] busy;
  assign trig = sel == 2'h0 ? TRIG_L0 : sel == 2'h1 ? TRIG_L1 :
    sel == 2'h2 ? TRIG_L2 : TRIG_L3;
  assign lo = sel == 2'h0 ? TRIG_NONE : sel == 2'h1 ? TRIG_L0 :
    sel == 2'h2 ? TRIG_L1 : TRIG_L2;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {au, ac, lp, sw, rq, sel, msk} <= '0;
      dv <= RST_DIVISOR;
      cnt <= '0;
      busy <= '0;
    end else begin
      if (wr_en && addr == OFF_MODEM_CTRL) begin
        au <= wdata[MC_AUTO_RTS];
        ac <= wdata[MC_AUTO_CTS];
        lp <= wdata[MC_LOOP];
        // the software bit is only honoured when auto rts was off
        sw <= !au && !wdata[MC_AUTO_RTS];
        if (!au) rq <= wdata[MC_REQ];
      end
      if (wr_en && addr == OFF_FIFO_CTRL) sel <= wdata[FC_TRIG_LO+:2];
      if (wr_en && addr == OFF_INT_MASK) msk <= wdata[IS_W-1:0];
      if (wr_en && addr == OFF_DIVISOR) dv <= wdata[15:0];
      cnt <= cnt + 5'(rx_valid && cnt < FIFO_DEPTH)
        - 5'(rd_en && addr == OFF_DATA && cnt != 5'h0);
      // tracks one whole frame so data bits are not taken for starts
      if (busy != 20'h0) busy <= busy - 20'h1;
      else if (!txd) busy <= 20'(dv + 16'h1) * 20'ha - 20'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  manual_rts_a: assert property (sw && !lp |-> rts_n == !rq)
    else $error("rts pin differs from software bit");
  loop_rts_a: assert property (lp |-> rts_n)
    else $error("rts active in loopback");
  rts_high_a: assert property (au && cnt >= trig |-> rts_n)
    else $error("rts not released at trigger");
  rts_low_a: assert property (au && !lp && cnt <= lo
    |-> !rts_n)
    else $error("rts not reasserted at lower level");
  rts_hold_a: assert property (au && $past(au) && $stable(sel)
    && $stable(lp) && cnt > lo && cnt < trig |-> $stable(rts_n))
    else $error("rts moved between thresholds");
  req_copy_a: assert property ($past(rd_en && addr == OFF_MODEM_CTRL
    && au && !lp) && $stable(rts_n) && $past(rts_n, 2) == rts_n
    |-> rdata[MC_REQ] == !rts_n)
    else $error("rts bit does not mirror the pin");
  cts_gate_a: assert property (ac && !lp && busy == 20'h0
    && $fell(txd) |-> !($past(cts_n, 2) && $past(cts_n, 3)
    && $past(cts_n, 4) && $past(cts_n, 5) && $past(cts_n, 6)))
    else $error("character started without cts");
  rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("read data outside its cycle");
  unmapped_a: assert property ($past(rd_en) && $past(addr) > OFF_DIVISOR
    |-> rdata == 32'h0)
    else $error("unmapped read not zero");
  irq_mask_a: assert property (msk == 4'h0 && $past(msk) == 4'h0 |-> !irq)
    else $error("interrupt with everything masked");
  rts_full_c: cover property (au && rts_n && cnt == trig + 5'h1);
  cts_start_c: cover property (ac && busy == 20'h0 && $fell(txd));
  irq_c: cover property ($rose(irq));
endmodule
bind uaf_flow_top uaf_flow_properties chk (.clk(clk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .rx_valid(rx_valid), .cts_n(cts_n), .rts_n(rts_n), .txd(txd), .irq(irq));

// ---- dv/uaf_remote.sv ----
// remote uart model: drives cts and feeds bytes while rts allows
`timescale 1ns/100ps
module uaf_remote (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench controls
  input wire logic send,
  input wire logic stop_tx,
  // modem pins
  input wire logic rts_n,
  output logic cts_n,
  // received byte stream
  output logic rx_valid,
  output logic [7:0] rx_data
);
  logic [7:0] seq;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seq <= 8'h00;
      rx_valid <= 1'b0;
      rx_data <= 8'hff;
      cts_n <= 1'b1;
    end else begin
      // bench flips stop_tx only between characters
      cts_n <= stop_tx;
      // rts is seen a cycle late, so one extra byte follows
      rx_valid <= send && !rts_n;
      rx_data <= (send && !rts_n) ? seq : ~rx_data;
      if (send && !rts_n) seq <= seq + 8'h01;
    end
  end
endmodule

// ---- dv/uaf_flow_top_bench.sv ----
// self-checking bench for the flow control block
`timescale 1ns/100ps
module uaf_flow_top_bench
  import uaf_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic send = 1'b0, stop_tx = 1'b1;
  logic [7:0] addr = 8'h00, nb = 8'h00, rx_data;
  logic [31:0] wdata = 32'h0, fr = 32'h0, rdata;
  logic rx_valid, cts_n, rts_n, dtr_n, txd, irq;
  logic [4:0] trg [4] = '{TRIG_L0, TRIG_L1, TRIG_L2, TRIG_L3};
  logic [4:0] low [4] = '{TRIG_NONE, TRIG_L0, TRIG_L1, TRIG_L2};
  int err_count = 0, n_tests = 0, cyc = 0;
  always #25 clk = ~clk;
  uaf_flow_top dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rx_valid(rx_valid),
    .rx_data(rx_data), .cts_n(cts_n), .rts_n(rts_n), .dtr_n(dtr_n),
    .txd(txd), .irq(irq));
  uaf_remote far (.clk(clk), .rst_n(rst_n), .send(send), .stop_tx(stop_tx),
    .rts_n(rts_n), .cts_n(cts_n), .rx_valid(rx_valid), .rx_data(rx_data));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
    input logic [31:0] m);
    n_tests++;
    if ((got & m) !== (exp & m)) begin
      err_count++;
      $display("FAIL %0t got %h want %h", $time, got & m, exp & m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    // one idle edge so a following write never re-raises the strobe at once
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
    input logic [31:0] m);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    check(rdata, exp, m);
    @(posedge clk);
  endtask
  // pins packed as irq, txd, dtr_n, rts_n
  task automatic pin(input logic [3:0] m, input logic [3:0] exp);
    repeat (2) @(negedge clk);
    check({28'h0, irq, txd, dtr_n, rts_n}, {28'h0, exp}, {28'h0, m});
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFF_MODEM_CTRL, 32'h0, 32'hc2);
    pin(4'hf, 4'h7);
    wr(OFF_MODEM_CTRL, 32'h3);
    pin(4'h3, 4'h0);
    wr(OFF_MODEM_CTRL, 32'h13);
    pin(4'h3, 4'h3);
    rd(OFF_MODEM_CTRL, 32'h10, 32'h13);
    rd(8'hfc, 32'h0, 32'hffffffff);
    for (int t = 0; t < 4; t++) begin
      wr(OFF_FIFO_CTRL, 32'(t) << FC_TRIG_LO);
      wr(OFF_MODEM_CTRL, 32'h40); // bit 5 stays clear
      send <= 1'b1;
      for (int i = 0; i < 40 && rts_n !== 1'b1; i++) @(posedge clk);
      send <= 1'b0;
      rd(OFF_LINE_STAT, 32'(trg[t]) + 1, 32'h1f);
      rd(OFF_MODEM_CTRL, 32'h40, 32'hc2);
      wr(OFF_MODEM_CTRL, 32'h42);
      rd(OFF_MODEM_CTRL, 32'h40, 32'h2);
      for (int n = trg[t] + 1; n > 0; n--) begin
        rd(OFF_DATA, {24'h0, nb}, 32'hff);
        nb++;
        pin(4'h1, (n - 1 > low[t]) ? 4'h1 : 4'h0);
      end
    end
    wr(OFF_MODEM_CTRL, 32'h80);
    wr(OFF_DIVISOR, 32'h1);
    rd(OFF_MODEM_STAT, 32'h0, 32'h10);
    wr(OFF_INT_STAT, 32'hf);
    wr(OFF_DATA, 32'h5a);
    for (int i = 0; i < 10; i++) pin(4'h4, 4'h4);
    rd(OFF_LINE_STAT, 32'h100, 32'h100);
    stop_tx <= 1'b0;
    // mid-cycle samples stay clear of the edges that move txd
    for (int i = 0; i < 40 && txd !== 1'b0; i++) @(negedge clk);
    for (int i = 0; i < 10; i++) begin
      fr[i] = txd;
      repeat (2) @(negedge clk);
    end
    @(posedge clk);
    check(fr, {22'h0, 1'b1, 8'h5a, 1'b0}, 32'h3ff);
    rd(OFF_MODEM_STAT, 32'h11, 32'h11);
    rd(OFF_INT_STAT, 32'h2, 32'h6);
    pin(4'h8, 4'h0);
    wr(OFF_INT_MASK, 32'h2);
    pin(4'h8, 4'h8);
    wr(OFF_INT_STAT, 32'h2);
    pin(4'h8, 4'h0);
    wr(OFF_FIFO_CTRL, 32'h8);
    stop_tx <= 1'b1;
    repeat (6) @(posedge clk);
    rd(OFF_MODEM_STAT, 32'h1, 32'h11);
    rd(OFF_INT_STAT, 32'h4, 32'h4);
    print_verdict();
  end
endmodule
